// File: jac_map.svh
`ifndef JAC_MAP_SVH
`define JAC_MAP_SVH
// ==================================================
// register byte offsets
`define JAC_OFS_CTRL      8'h00
`define JAC_OFS_CFG       8'h04
`define JAC_OFS_INCH_DIST 8'h08
`define JAC_OFS_ACC_TIME  8'h0C
`define JAC_OFS_DEC_TIME  8'h10
`define JAC_OFS_SPEED     8'h14
`define JAC_OFS_STATUS    8'h18
`define JAC_OFS_IRQ_STAT  8'h1C
`define JAC_OFS_IRQ_CLR   8'h20
`define JAC_OFS_IRQ_EN    8'h24
`define JAC_OFS_POS       8'h28
// ==================================================
// control bit positions
`define JAC_CTRL_FWD      0
`define JAC_CTRL_REV      1
`define JAC_CTRL_INCH     2
`define JAC_CTRL_ERR_CLR  3
// config bit positions
`define JAC_CFG_LIM_EN    0
`define JAC_CFG_STOP_ALL  1
`define JAC_CFG_ALARM_HOST 2
`define JAC_CFG_HOST_CONT 3
// status bit positions
`define JAC_ST_BUSY       0
`define JAC_ST_DONE       1
`define JAC_ST_SET_ERR    2
`define JAC_ST_LIM_ERR    3
`define JAC_ST_DIR        4
`define JAC_ST_STOPPED_EXT 5
// interrupt bit positions
`define JAC_IRQ_DONE      0
`define JAC_IRQ_SET_ERR   1
`define JAC_IRQ_LIM_ERR   2
// ==================================================
// setting ranges and reset values
`define JAC_INCH_MAX      32'h7FFFFFFF
`define JAC_TIME_MAX      32'h00007FFF
`define JAC_SPEED_MAX     32'h00FFFFFF
`define JAC_RST_INCH      32'h00000000
`define JAC_RST_ACC       32'h00000064
`define JAC_RST_DEC       32'h00000064
`define JAC_RST_SPEED     32'h00002710
`define JAC_CFG_RST       4'h1
// ==================================================
// timing: one millisecond of acc or dec time
`define JAC_MS_NS         1000000
`define JAC_CLK_NS        10
`define JAC_MS_CYC        (`JAC_MS_NS / `JAC_CLK_NS)
`endif

// File: jac_pkg.sv
package jac_pkg;
   // motion state of the axis
   typedef enum logic [2:0] {
      JAC_IDLE,
      JAC_ACCEL,
      JAC_RUN,
      JAC_DECEL
   } jac_state_e;
endpackage

// File: jac_axis.sv
`timescale 1ns/1ns
`include "jac_map.svh"
// Overview of operation
// - In continuous mode the axis moves as long as a forward or reverse request level is held.
// - In inching mode a move starts only on the rising edge of a forward or reverse request.
// - The host picks continuous or inching by the inching-select bit and the block follows it.
// - An inching start with inching distance out of range, or any start with acc time, dec time or speed out of range, raises a setting error.
// - With limits on, a forward start is refused with error on positive limit, reverse on negative limit.
// - Moving into the active limit of the travel direction causes a decelerating stop and a limit error.
// - With stop-all configured, an error on any axis also stops this axis.
// - Without host alarm, or with host alarm and continue, a held request restarts the jog after a stop.
// - Busy is set when jog control begins and cleared when motion finishes.
// - Done is set on completion and held until the next motion begins.
// - An inching move outputs its full pulse count even if the request drops early.
// - Speed changes take effect only in continuous jog; a rise ramps with the acc time latched at start, a drop applies at the next ramp tick.
module jac_axis #(
   parameter int MS_CYC = `JAC_MS_CYC
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic lim_pos,
   input wire logic lim_neg,
   input wire logic other_axis_err,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic step_pulse,
   output logic step_dir,
   output logic axis_err,
   output logic irq
);
   // ==================================================
   // declarations
   jac_pkg::jac_state_e state_reg;
   logic [3:0] ctrl_reg;
   logic [3:0] cfg_reg;
   logic [31:0] inch_reg, acc_reg, dec_reg, speed_reg;
   logic [31:0] acc_lat_reg, dec_lat_reg, inch_lat_reg;
   logic [31:0] cur_speed_reg, tgt_speed_reg, ramp_cnt_reg, step_acc_reg, pulses_reg, pos_reg;
   logic busy_reg, done_reg, set_err_reg, lim_err_reg, dir_reg, inch_mode_reg, ext_stop_reg;
   logic [2:0] irq_stat_reg, irq_en_reg;
   logic [1:0] lp_sync_reg, ln_sync_reg, oe_sync_reg;
   logic fwd_d_reg, rev_d_reg;
   logic aw_got_reg, w_got_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_fire, start_ok, start_req, start_dir, set_bad, lim_block;
   logic stop_req, inch_end, err_ev, done_ev, wr_ctrl, wr_cfg, wr_clr;
   logic lp, ln, oe, fwd_rise, rev_rise;

   // merge a write with byte enables
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            merge[i*8 +: 8] = d[i*8 +: 8];
         end
      end
   endfunction

   // speed step per ramp tick, at least one
   function automatic logic [31:0] ramp_step(input logic [31:0] spd, input logic [31:0] ms);
      ramp_step = (ms == 32'h00000000) ? spd : ((spd / ms) == 32'h00000000 ? 32'h00000001 : spd / ms);
   endfunction

   // ==================================================
   // pin synchronisers for limits and the shared error line
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lp_sync_reg <= 2'h0;
         ln_sync_reg <= 2'h0;
         oe_sync_reg <= 2'h0;
      end else if (clk_en) begin
         lp_sync_reg <= {lp_sync_reg[0], lim_pos};
         ln_sync_reg <= {ln_sync_reg[0], lim_neg};
         oe_sync_reg <= {oe_sync_reg[0], other_axis_err};
      end
   end
   assign lp = lp_sync_reg[1];
   assign ln = ln_sync_reg[1];
   assign oe = oe_sync_reg[1];

   // ==================================================
   // axi4-lite write path: address and data in either order
   assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (clk_en) begin
         s_axi_awready <= !aw_got_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_got_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_reg > `JAC_OFS_POS || aw_addr_reg[1:0] != 2'h0) ? 2'h2 : 2'h0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
         end
      end
   end

   // write decode strobes
   assign wr_ctrl = wr_fire && aw_addr_reg == `JAC_OFS_CTRL;
   assign wr_cfg = wr_fire && aw_addr_reg == `JAC_OFS_CFG;
   assign wr_clr = wr_fire && aw_addr_reg == `JAC_OFS_IRQ_CLR;

   // software registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= 4'h0;
         cfg_reg <= `JAC_CFG_RST;
         inch_reg <= `JAC_RST_INCH;
         acc_reg <= `JAC_RST_ACC;
         dec_reg <= `JAC_RST_DEC;
         speed_reg <= `JAC_RST_SPEED;
         irq_en_reg <= 3'h0;
      end else if (clk_en) begin
         ctrl_reg[`JAC_CTRL_ERR_CLR] <= 1'b0; // self-clearing error reset
         if (wr_ctrl) begin
            ctrl_reg <= 4'(merge({28'h0, ctrl_reg}, w_data_reg, w_strb_reg));
         end else if (wr_cfg) begin
            cfg_reg <= 4'(merge({28'h0, cfg_reg}, w_data_reg, w_strb_reg));
         end else if (wr_fire && aw_addr_reg == `JAC_OFS_INCH_DIST) begin
            inch_reg <= merge(inch_reg, w_data_reg, w_strb_reg);
         end else if (wr_fire && aw_addr_reg == `JAC_OFS_ACC_TIME) begin
            acc_reg <= merge(acc_reg, w_data_reg, w_strb_reg);
         end else if (wr_fire && aw_addr_reg == `JAC_OFS_DEC_TIME) begin
            dec_reg <= merge(dec_reg, w_data_reg, w_strb_reg);
         end else if (wr_fire && aw_addr_reg == `JAC_OFS_SPEED) begin
            speed_reg <= merge(speed_reg, w_data_reg, w_strb_reg);
         end else if (wr_fire && aw_addr_reg == `JAC_OFS_IRQ_EN) begin
            irq_en_reg <= w_data_reg[2:0];
         end
      end
   end

   // ==================================================
   // axi4-lite read path, one cycle after the address is taken
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            if (s_axi_araddr == `JAC_OFS_CTRL) begin
               s_axi_rdata <= {28'h0, ctrl_reg};
            end else if (s_axi_araddr == `JAC_OFS_CFG) begin
               s_axi_rdata <= {28'h0, cfg_reg};
            end else if (s_axi_araddr == `JAC_OFS_INCH_DIST) begin
               s_axi_rdata <= inch_reg;
            end else if (s_axi_araddr == `JAC_OFS_ACC_TIME) begin
               s_axi_rdata <= acc_reg;
            end else if (s_axi_araddr == `JAC_OFS_DEC_TIME) begin
               s_axi_rdata <= dec_reg;
            end else if (s_axi_araddr == `JAC_OFS_SPEED) begin
               s_axi_rdata <= speed_reg;
            end else if (s_axi_araddr == `JAC_OFS_STATUS) begin
               s_axi_rdata <= {26'h0, ext_stop_reg, dir_reg, lim_err_reg, set_err_reg, done_reg, busy_reg};
            end else if (s_axi_araddr == `JAC_OFS_IRQ_STAT) begin
               s_axi_rdata <= {29'h0, irq_stat_reg};
            end else if (s_axi_araddr == `JAC_OFS_IRQ_EN) begin
               s_axi_rdata <= {29'h0, irq_en_reg};
            end else if (s_axi_araddr == `JAC_OFS_POS) begin
               s_axi_rdata <= pos_reg;
            end else begin
               s_axi_rdata <= 32'h00000000; // unmapped or write-only
               s_axi_rresp <= (s_axi_araddr == `JAC_OFS_IRQ_CLR) ? 2'h0 : 2'h2;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==================================================
   // start decision
   assign fwd_rise = ctrl_reg[`JAC_CTRL_FWD] && !fwd_d_reg;
   assign rev_rise = ctrl_reg[`JAC_CTRL_REV] && !rev_d_reg;
   // mode follows the select bit at start
   always_comb begin
      if (ctrl_reg[`JAC_CTRL_INCH]) begin
         start_req = fwd_rise || rev_rise; // edge only
         start_dir = !fwd_rise;
      end else begin
         start_req = ctrl_reg[`JAC_CTRL_FWD] ^ ctrl_reg[`JAC_CTRL_REV]; // level
         start_dir = ctrl_reg[`JAC_CTRL_REV];
      end
   end
   assign set_bad = (ctrl_reg[`JAC_CTRL_INCH] && (inch_reg == 32'h00000000 || inch_reg > `JAC_INCH_MAX))
      || acc_reg > `JAC_TIME_MAX || dec_reg > `JAC_TIME_MAX
      || speed_reg == 32'h00000000 || speed_reg > `JAC_SPEED_MAX;
   // only the limit on the travel side blocks
   assign lim_block = cfg_reg[`JAC_CFG_LIM_EN] && (start_dir ? ln : lp);
   // a held request restarts only while errors do not latch the axis
   assign start_ok = start_req && state_reg == jac_pkg::JAC_IDLE && !ext_stop_reg
      && !((set_err_reg || lim_err_reg) && cfg_reg[`JAC_CFG_ALARM_HOST] && !cfg_reg[`JAC_CFG_HOST_CONT]);
   // stop on own limit, stop-all, or dropped level
   assign stop_req = (cfg_reg[`JAC_CFG_LIM_EN] && (dir_reg ? ln : lp))
      || (cfg_reg[`JAC_CFG_STOP_ALL] && oe)
      || (!inch_mode_reg && !(dir_reg ? ctrl_reg[`JAC_CTRL_REV] : ctrl_reg[`JAC_CTRL_FWD]));
   assign inch_end = inch_mode_reg && pulses_reg >= inch_lat_reg;
   assign err_ev = start_ok && (set_bad || lim_block);
   assign done_ev = state_reg == jac_pkg::JAC_DECEL
      && cur_speed_reg == 32'h00000000 && ramp_cnt_reg == 32'h00000000;

   // ==================================================
   // motion state machine with linear ramps
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= jac_pkg::JAC_IDLE;
         fwd_d_reg <= 1'b0;
         rev_d_reg <= 1'b0;
         dir_reg <= 1'b0;
         inch_mode_reg <= 1'b0;
         acc_lat_reg <= 32'h00000000;
         dec_lat_reg <= 32'h00000000;
         inch_lat_reg <= 32'h00000000;
         tgt_speed_reg <= 32'h00000000;
         cur_speed_reg <= 32'h00000000;
         ramp_cnt_reg <= 32'h00000000;
      end else if (clk_en) begin
         fwd_d_reg <= ctrl_reg[`JAC_CTRL_FWD];
         rev_d_reg <= ctrl_reg[`JAC_CTRL_REV];
         ramp_cnt_reg <= (ramp_cnt_reg == 32'h00000000) ? 32'(MS_CYC - 1) : ramp_cnt_reg - 32'h00000001;
         case (state_reg)
            jac_pkg::JAC_IDLE: begin
               if (start_ok && !set_bad && !lim_block) begin
                  state_reg <= jac_pkg::JAC_ACCEL;
                  dir_reg <= start_dir;
                  inch_mode_reg <= ctrl_reg[`JAC_CTRL_INCH];
                  acc_lat_reg <= acc_reg; // latched for the whole move
                  dec_lat_reg <= dec_reg;
                  inch_lat_reg <= inch_reg;
                  tgt_speed_reg <= speed_reg;
                  cur_speed_reg <= 32'h00000000;
                  ramp_cnt_reg <= 32'(MS_CYC - 1);
               end
            end
            jac_pkg::JAC_ACCEL, jac_pkg::JAC_RUN: begin
               if (!inch_mode_reg) begin
                  tgt_speed_reg <= speed_reg; // live speed change
               end
               if (stop_req || inch_end) begin
                  state_reg <= jac_pkg::JAC_DECEL;
               end else if (ramp_cnt_reg == 32'h00000000) begin
                  if (cur_speed_reg + ramp_step(tgt_speed_reg, acc_lat_reg) < tgt_speed_reg) begin
                     cur_speed_reg <= cur_speed_reg + ramp_step(tgt_speed_reg, acc_lat_reg);
                     state_reg <= jac_pkg::JAC_ACCEL;
                  end else begin
                     cur_speed_reg <= tgt_speed_reg;
                     state_reg <= jac_pkg::JAC_RUN;
                  end
               end
            end
            jac_pkg::JAC_DECEL: begin
               if (inch_end && inch_mode_reg) begin
                  cur_speed_reg <= 32'h00000000; // exact pulse count reached
               end else if (ramp_cnt_reg == 32'h00000000) begin
                  cur_speed_reg <= (cur_speed_reg > ramp_step(tgt_speed_reg, dec_lat_reg))
                     ? cur_speed_reg - ramp_step(tgt_speed_reg, dec_lat_reg) : 32'h00000000;
               end
               if (done_ev) begin
                  state_reg <= jac_pkg::JAC_IDLE;
               end
            end
            default: state_reg <= jac_pkg::JAC_IDLE;
         endcase
      end
   end

   // ==================================================
   // pulse generator: accumulate speed, one step per 1e8 overflow
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         step_acc_reg <= 32'h00000000;
         step_pulse <= 1'b0;
         step_dir <= 1'b0;
         pulses_reg <= 32'h00000000;
         pos_reg <= 32'h00000000;
      end else if (clk_en) begin
         step_dir <= dir_reg;
         step_pulse <= 1'b0;
         if (state_reg == jac_pkg::JAC_IDLE) begin
            step_acc_reg <= 32'h00000000;
            if (start_ok) begin
               pulses_reg <= 32'h00000000;
            end
         end else if (!inch_end) begin
            if (step_acc_reg + cur_speed_reg >= 32'd100000000) begin
               step_acc_reg <= step_acc_reg + cur_speed_reg - 32'd100000000;
               step_pulse <= 1'b1;
               pulses_reg <= pulses_reg + 32'h00000001; // counted to the end
               pos_reg <= dir_reg ? pos_reg - 32'h00000001 : pos_reg + 32'h00000001;
            end else begin
               step_acc_reg <= step_acc_reg + cur_speed_reg;
            end
         end
      end
   end

   // ==================================================
   // busy, done and error flags
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         set_err_reg <= 1'b0;
         lim_err_reg <= 1'b0;
         ext_stop_reg <= 1'b0;
         axis_err <= 1'b0;
      end else if (clk_en) begin
         if (start_ok && !set_bad && !lim_block) begin
            busy_reg <= 1'b1;
            done_reg <= 1'b0; // held until the next start
         end else if (done_ev) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
         end
         // set wins over the error clear
         if (err_ev && set_bad) begin
            set_err_reg <= 1'b1;
         end else if (ctrl_reg[`JAC_CTRL_ERR_CLR]) begin
            set_err_reg <= 1'b0;
         end
         if ((err_ev && !set_bad) || (state_reg != jac_pkg::JAC_IDLE && state_reg != jac_pkg::JAC_DECEL
               && cfg_reg[`JAC_CFG_LIM_EN] && (dir_reg ? ln : lp))) begin
            lim_err_reg <= 1'b1;
         end else if (ctrl_reg[`JAC_CTRL_ERR_CLR]) begin
            lim_err_reg <= 1'b0;
         end
         // stop-all holds the axis until the other axis error drops
         ext_stop_reg <= cfg_reg[`JAC_CFG_STOP_ALL] && oe;
         axis_err <= set_err_reg || lim_err_reg;
      end
   end

   // ==================================================
   // interrupt: sticky status, set wins over clear
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_stat_reg <= 3'h0;
         irq <= 1'b0;
      end else if (clk_en) begin
         irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? w_data_reg[2:0] : 3'h0))
            | {lim_err_reg & !axis_err, set_err_reg & !axis_err, done_ev};
         irq <= |(irq_stat_reg & irq_en_reg);
      end
   end
endmodule // jac_axis

// File: jac_axis_properties.sv
`timescale 1ns/1ns
// ==================================================
// port checks for one jog axis
module jac_axis_props (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic lim_pos,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic step_pulse,
   input wire logic step_dir,
   input wire logic axis_err
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // both halves of a write taken on the same edge
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // forward pulse with the limit up past the synchroniser
   sequence s_fwd_on_lim;
      lim_pos [*4] ##0 (step_pulse && !step_dir);
   endsequence
   a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before bready");
   a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response changed before rready");
   a_write_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
      else $error("no write response two cycles after handshake");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read response one cycle after address");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken with response pending");
   a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready wider than one cycle");
   a_pulse_single: assert property (step_pulse |=> !step_pulse)
      else $error("step pulse wider than one cycle");
   a_fwd_limit_err: assert property (s_fwd_on_lim |-> ##[0:6] axis_err)
      else $error("forward motion into limit without error");
endmodule // jac_axis_props
bind jac_axis jac_axis_props u_props (.core_clk, .resetn, .lim_pos, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .step_pulse, .step_dir, .axis_err);

// File: jac_host_model.sv
`timescale 1ns/1ns
`include "jac_map.svh"
// ==================================================
// host program: register master and request writer
module jac_host_model (
   input wire logic core_clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // idle bus from time zero
   initial begin
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = 52'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
   end
   // released payload shows its inverse
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, 4'hF};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge core_clk);
         if (s_axi_awready === 1'h1) {s_axi_awvalid, s_axi_awaddr} <= {1'h0, ~a};
         if (s_axi_wready === 1'h1) {s_axi_wvalid, s_axi_wdata} <= {1'h0, ~v};
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
   endtask
   // read waits as long as it takes
   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      @(posedge core_clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge core_clk);
         if (s_axi_arready === 1'h1) {s_axi_arvalid, s_axi_araddr} <= {1'h0, ~a};
      end while (s_axi_rvalid !== 1'h1);
      {v, e} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'h0;
   endtask
   // req is {inch, rev, fwd}; gate masks requests while another axis is in error
   task ctrl(input logic [2:0] req, input logic gate);
      wr(`JAC_OFS_CTRL, {29'h0, req[2], req[1:0] & {2{!gate}}});
   endtask
endmodule // jac_host_model

// File: tb_top.sv
`timescale 1ns/1ns
`include "jac_map.svh"
module tb_top;
   logic core_clk = 0, resetn = 0, clk_en = 1, lim_pos = 0, lim_neg = 0, other_axis_err = 0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, step_pulse, step_dir, axis_err, irq;
   int err_total = 0, cmp_count = 0, pcnt = 0, cyc = 0, p0;
   // ten cycles per ramp millisecond
   jac_axis #(.MS_CYC(10)) u_dut (.core_clk, .resetn, .clk_en, .lim_pos, .lim_neg, .other_axis_err,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .step_pulse,
      .step_dir, .axis_err, .irq);
   jac_host_model u_h (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // clock and pulse tally
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) if (step_pulse === 1'h1) pcnt++;
   // ==================================================
   // compare and report
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      u_h.rd(a, d, r);
      chk(d, exp);
   endtask
   // polls status; the run limit ends a hang
   task wait_st(input logic [31:0] m, input logic [31:0] v);
      do u_h.rd(`JAC_OFS_STATUS, d, r); while ((d & m) !== v);
      chk(d & m, v);
   endtask
   task stop_test();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // run limit well above what the sequence needs
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   // ==================================================
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      resetn <= 1'h1;
      rd_chk(`JAC_OFS_CFG, 32'h1);
      rd_chk(`JAC_OFS_ACC_TIME, 32'h64);
      rd_chk(`JAC_OFS_DEC_TIME, 32'h64);
      rd_chk(`JAC_OFS_SPEED, 32'h2710);
      rd_chk(`JAC_OFS_INCH_DIST, 32'h0);
      u_h.rd(8'h30, d, r);
      chk({30'h0, r}, 32'h2);
      // zero inching distance; irq masked, enabled, cleared
      u_h.ctrl(3'h5, 1'h0);
      wait_st(32'h4, 32'h4);
      chk({30'h0, axis_err, irq}, 32'h2);
      u_h.wr(`JAC_OFS_IRQ_EN, 32'h7);
      rd_chk(`JAC_OFS_IRQ_STAT, 32'h2);
      chk({31'h0, irq}, 32'h1);
      u_h.wr(`JAC_OFS_IRQ_CLR, 32'h7);
      u_h.wr(`JAC_OFS_CTRL, 32'h8);
      rd_chk(`JAC_OFS_IRQ_STAT, 32'h0);
      chk({30'h0, axis_err, irq}, 32'h0);
      // inching: request dropped early, then held
      u_h.wr(`JAC_OFS_INCH_DIST, 32'h5);
      u_h.wr(`JAC_OFS_ACC_TIME, 32'h1);
      u_h.wr(`JAC_OFS_DEC_TIME, 32'h1);
      u_h.wr(`JAC_OFS_SPEED, 32'h00FFFFFF);
      p0 = pcnt;
      u_h.ctrl(3'h5, 1'h0);
      u_h.ctrl(3'h4, 1'h0);
      wait_st(32'h3, 32'h2);
      chk(32'(pcnt - p0), 32'h5);
      u_h.ctrl(3'h5, 1'h0);
      wait_st(32'h3, 32'h1);
      wait_st(32'h3, 32'h2);
      repeat (100) @(posedge core_clk);
      chk(32'(pcnt - p0), 32'hA);
      // continuous reverse on the level, speed change mid-run
      u_h.ctrl(3'h2, 1'h0);
      wait_st(32'h13, 32'h11);
      p0 = pcnt;
      repeat (300) @(posedge core_clk);
      chk({31'h0, step_dir}, 32'h1);
      chk(32'((pcnt - p0) > 20), 32'h1);
      u_h.wr(`JAC_OFS_SPEED, 32'h00100000);
      p0 = pcnt;
      repeat (300) @(posedge core_clk);
      chk(32'((pcnt - p0) < 12), 32'h1);
      u_h.ctrl(3'h0, 1'h0);
      wait_st(32'h3, 32'h2);
      u_h.wr(`JAC_OFS_SPEED, 32'h00FFFFFF);
      // limit at start: forward refused, reverse allowed
      lim_pos <= 1'h1;
      p0 = pcnt;
      u_h.ctrl(3'h1, 1'h0);
      wait_st(32'h9, 32'h8);
      chk(32'(pcnt - p0), 32'h0);
      u_h.wr(`JAC_OFS_CTRL, 32'h8);
      u_h.ctrl(3'h2, 1'h0);
      wait_st(32'h9, 32'h1);
      u_h.ctrl(3'h0, 1'h0);
      lim_pos <= 1'h0;
      wait_st(32'h1, 32'h0);
      // limit reached while moving forward
      u_h.ctrl(3'h1, 1'h0);
      wait_st(32'h1, 32'h1);
      lim_pos <= 1'h1;
      wait_st(32'h9, 32'h8);
      u_h.wr(`JAC_OFS_CTRL, 32'h8);
      lim_pos <= 1'h0;
      // stop-all on another axis error, restart with request held
      u_h.wr(`JAC_OFS_CFG, 32'h3);
      u_h.ctrl(3'h1, 1'h0);
      wait_st(32'h1, 32'h1);
      other_axis_err <= 1'h1;
      wait_st(32'h21, 32'h20);
      other_axis_err <= 1'h0;
      wait_st(32'h1, 32'h1);
      u_h.ctrl(3'h0, 1'h0);
      wait_st(32'h3, 32'h2);
      stop_test();
   end
endmodule // tb_top
